// [rtl/mrd_pkg.sv]
// Functional notes
// [R1] Build date register is read-only; a write is refused with an error.
// [R2] A good build date read returns 0x000C and selects the 12-byte date.
// [R3] Date: 2-digit day, hyphen, 3-letter month, hyphen, 4-digit year, null.
// [R4] The release register is read-only; a write is refused with an error.
// [R5] A good release read returns its null-terminated length, at most 80.
// [R6] Release holds a protocol field plus a firmware or hardware field.
// [R7] Fields are joined by colons; each is an id, a space and x.y.z decimals.
// [R8] Every version number is 0 to 255, in major, minor, patch order.
// [R9] The release string also carries an application space field.
// [R10] Newer releases have larger major and minor; patch is never compared.
// [R11] A failed string read answers the failed status, a cause and 0x0000.
// [R12] Read-only compat register names the oldest compatible release.
// [R13] After a good read the host fetches bytes to the null or the length.
package mrd_pkg;

  // ******************************************
  // bus and register map
  // ******************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [5:0]  IDX_BUILD_DATE  = 6'h05;
  localparam logic [5:0]  IDX_RELEASE     = 6'h06;
  localparam logic [5:0]  IDX_COMPAT      = 6'h07;
  localparam logic [5:0]  IDX_LAST_STATUS = 6'h10;
  localparam logic [5:0]  IDX_STR_LEN     = 6'h11;
  localparam logic [5:0]  IDX_STR_DATA    = 6'h12;
  localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h13;
  localparam logic [5:0]  IDX_IRQ_MASK    = 6'h14;

  // ******************************************
  // field layout and reset values
  // ******************************************
  localparam int          ST_FAILED_BIT   = 8;
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_WR_REJECT   = 0;
  localparam int          IRQ_RD_FAIL     = 1;
  localparam int          IRQ_STR_DONE    = 2;
  localparam logic [2:0]  IRQ_STATUS_RST  = 3'h0;
  localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;
  localparam logic [15:0] DATE_LEN        = 16'h000C;
  localparam int          STR_MAX         = 80;
  localparam int          VER_MAX         = 255;

  // ******************************************
  // characters
  // ******************************************
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam logic [7:0]  CH_DOT          = 8'h2E;
  localparam logic [7:0]  CH_COLON        = 8'h3A;
  localparam logic [7:0]  CH_SPACE        = 8'h20;
  localparam logic [7:0]  CH_HYPHEN       = 8'h2D;
  localparam logic [7:0]  CH_NUL          = 8'h00;
  localparam logic [287:0] MONTH_CODES    =
    "JANFEBMARAPRMAYJUNJULAUGSEPOCTNOVDEC";

  // ******************************************
  // types
  // ******************************************
  typedef enum logic [2:0] {
    ERR_NONE                = 3'h0,
    ERR_COMMAND_IN_PROGRESS = 3'h1,
    ERR_COMMAND_IGNORED     = 3'h2,
    ERR_EXECUTION_FAILURE   = 3'h3,
    ERR_VENDOR_SPECIFIC     = 3'h4
  } mrd_err_t;

  typedef enum logic [1:0] {
    SEL_NONE    = 2'h0,
    SEL_DATE    = 2'h1,
    SEL_RELEASE = 2'h2,
    SEL_COMPAT  = 2'h3
  } mrd_sel_t;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'h0,
    BUS_ANSWER = 1'h1
  } mrd_bus_t;

endpackage

// [rtl/mrd_str_if.sv]
`timescale 1ns/1ps
interface mrd_str_if;
  import mrd_pkg::*;

  mrd_sel_t   sel;
  logic       load;
  logic       advance;
  logic [7:0] len;
  logic [7:0] dataByte;
  logic       atEnd;

  modport reader (
    input  sel,
    input  load,
    input  advance,
    output len,
    output dataByte,
    output atEnd
  );

  modport user (
    output sel,
    output load,
    output advance,
    input  len,
    input  dataByte,
    input  atEnd
  );
endinterface

// [rtl/mrd_string_reader.sv]
`timescale 1ns/1ps
module mrd_string_reader #(
  parameter logic [95:0]  DATE_STR   = '0,
  parameter logic [7:0]   DATE_N     = 8'h0C,
  parameter logic [639:0] REL_STR    = '0,
  parameter logic [7:0]   REL_N      = 8'h01,
  parameter logic [639:0] COMPAT_STR = '0,
  parameter logic [7:0]   COMPAT_N   = 8'h01
) (
  // clock and reset
  input wire logic   clk,
  input wire logic   rstn,
  input wire logic   clkEn,
  // string access
  mrd_str_if.reader  strPort
);
  import mrd_pkg::*;

  mrd_sel_t     strSel_reg;
  logic [7:0]   strOff_reg;
  logic [7:0]   curLen;
  logic [639:0] curStr;

  // ******************************************
  // selection of the current string
  // ******************************************
  assign curLen = (strSel_reg == SEL_DATE)    ? DATE_N :
                  (strSel_reg == SEL_RELEASE) ? REL_N :
                  (strSel_reg == SEL_COMPAT)  ? COMPAT_N : 8'h00;
  assign curStr = (strSel_reg == SEL_DATE)    ? {544'h0, DATE_STR} :
                  (strSel_reg == SEL_RELEASE) ? REL_STR :
                  (strSel_reg == SEL_COMPAT)  ? COMPAT_STR : 640'h0;

  assign strPort.len      = curLen;
  assign strPort.atEnd    = (strOff_reg >= curLen);
  assign strPort.dataByte = strPort.atEnd ? CH_NUL :
                            curStr[strOff_reg*8 +: 8];

  // ******************************************
  // pointer: reset by a good read, stops at end
  // ******************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strSel_reg <= SEL_NONE;
      strOff_reg <= 8'h00;
    end
    else if (clkEn)
    begin
      if (strPort.load)
      begin
        strSel_reg <= strPort.sel;
        strOff_reg <= 8'h00;
      end
      else if (strPort.advance && !strPort.atEnd)
      begin
        strOff_reg <= strOff_reg + 8'h01;
      end
    end
  end
endmodule

// [rtl/mrd_string_regs.sv]
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module mrd_string_regs #(
  parameter int          BUILD_DAY       = 1,
  parameter int          BUILD_MONTH     = 1,
  parameter int          BUILD_YEAR      = 2000,
  parameter logic [95:0] REL_VERSIONS    = 96'h010000_010000_010000_010000,
  parameter logic        REL_FW_ON       = 1'b1,
  parameter logic        REL_HW_ON       = 1'b1,
  parameter logic [95:0] COMPAT_VERSIONS = 96'h010000_010000_010000_010000,
  parameter logic        COMPAT_FW_ON    = 1'b1,
  parameter logic        COMPAT_HW_ON    = 1'b1
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         clkEn,
  // avalon-mm slave
  input  wire logic [mrd_pkg::ADDR_W-1:0]   avsAddress,
  input  wire logic                         avsRead,
  input  wire logic                         avsWrite,
  input  wire logic [mrd_pkg::DATA_W-1:0]   avsWriteData,
  input  wire logic [3:0]                   avsByteEnable,
  output logic      [mrd_pkg::DATA_W-1:0]   avsReadData,
  output logic                              avsWaitRequest,
  // module state
  input  wire logic                         stringFault,
  output logic                              irq
);
  import mrd_pkg::*;

  // ******************************************
  // string builders
  // ******************************************
  function automatic logic [95:0] mkDate(input int day, input int mon,
                                         input int year);
    logic [95:0] s;
    logic [23:0] m;
    s = '0;
    m = MONTH_CODES[(12 - mon)*24 +: 24];
    s[7:0]   = CH_ZERO + 8'(day / 10);                    // [R3]
    s[15:8]  = CH_ZERO + 8'(day % 10);
    s[23:16] = CH_HYPHEN;
    s[31:24] = m[23:16];
    s[39:32] = m[15:8];
    s[47:40] = m[7:0];
    s[55:48] = CH_HYPHEN;
    s[63:56] = CH_ZERO + 8'((year / 1000) % 10);
    s[71:64] = CH_ZERO + 8'((year / 100) % 10);
    s[79:72] = CH_ZERO + 8'((year / 10) % 10);
    s[87:80] = CH_ZERO + 8'(year % 10);
    s[95:88] = CH_NUL;
    return s;
  endfunction

  // fields in order: protocol, firmware, hardware, application space
  function automatic logic [647:0] mkRel(input logic [95:0] v,
                                         input logic fwOn,
                                         input logic hwOn);
    logic [639:0] s;
    logic [15:0]  id;
    logic         useIt;
    int           p;
    int           f;
    int           k;
    int           n;
    s = '0;
    p = 0;
    for (f = 0; f < 4; f++)
    begin
      useIt = (f == 0) || (f == 3) ||                     // [R6] [R9]
              (f == 1 && (fwOn || !hwOn)) || (f == 2 && hwOn);
      id = (f == 0) ? "PV" : (f == 1) ? "FW" : (f == 2) ? "HW" : "AS";
      if (useIt)
      begin
        if (p != 0)
        begin
          s[p*8 +: 8] = CH_COLON;                          // [R7]
          p++;
        end
        s[p*8 +: 8]     = id[15:8];
        s[(p+1)*8 +: 8] = id[7:0];
        s[(p+2)*8 +: 8] = CH_SPACE;
        p = p + 3;
        for (k = 0; k < 3; k++)
        begin
          n = int'(v[95 - (f*24 + k*8) -: 8]);            // [R8]
          if (n >= 100)
          begin
            s[p*8 +: 8] = CH_ZERO + 8'(n / 100);
            p++;
          end
          if (n >= 10)
          begin
            s[p*8 +: 8] = CH_ZERO + 8'((n / 10) % 10);
            p++;
          end
          s[p*8 +: 8] = CH_ZERO + 8'(n % 10);
          p++;
          if (k < 2)
          begin
            s[p*8 +: 8] = CH_DOT;
            p++;
          end
        end
      end
    end
    p++;
    return {8'(p), s};
  endfunction

  localparam logic [95:0]  DATE_STR   =
    mkDate(BUILD_DAY, BUILD_MONTH, BUILD_YEAR);
  localparam logic [647:0] REL_PACK   =
    mkRel(REL_VERSIONS, REL_FW_ON, REL_HW_ON);
  localparam logic [647:0] COMP_PACK  =
    mkRel(COMPAT_VERSIONS, COMPAT_FW_ON, COMPAT_HW_ON);
  localparam logic [639:0] REL_STR    = REL_PACK[639:0];
  localparam logic [7:0]   REL_LEN    = REL_PACK[647:640];
  localparam logic [639:0] COMPAT_STR = COMP_PACK[639:0];
  localparam logic [7:0]   COMPAT_LEN = COMP_PACK[647:640];

  // ******************************************
  // state
  // ******************************************
  mrd_bus_t       busState_reg;
  mrd_err_t       lastCause_reg;
  logic           lastFailed_reg;
  logic [IRQ_W-1:0] irqStatus_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [IRQ_W-1:0] irqStatus_next;
  logic [IRQ_W-1:0] irqEvents;
  logic [IRQ_W-1:0] irqClear;

  mrd_str_if strIf ();

  // ******************************************
  // address decode
  // ******************************************
  wire logic [5:0]  wordIdx   = avsAddress[7:2];
  wire logic        take      = clkEn && (avsRead || avsWrite) &&
                                (busState_reg == BUS_IDLE);
  wire logic        hitDate   = (wordIdx == IDX_BUILD_DATE);
  wire logic        hitRel    = (wordIdx == IDX_RELEASE);
  wire logic        hitCompat = (wordIdx == IDX_COMPAT);
  wire logic        hitLastSt = (wordIdx == IDX_LAST_STATUS);
  wire logic        hitStrLen = (wordIdx == IDX_STR_LEN);
  wire logic        hitStrDat = (wordIdx == IDX_STR_DATA);
  wire logic        hitIrqSt  = (wordIdx == IDX_IRQ_STATUS);
  wire logic        hitIrqMsk = (wordIdx == IDX_IRQ_MASK);
  wire logic        strHit    = hitDate || hitRel || hitCompat;
  wire logic        rdStrOk   = take && avsRead && strHit && !stringFault;
  wire logic        rdStrFail = take && avsRead && strHit && stringFault;
  wire logic        wrReject  = take && avsWrite && strHit;
  wire logic        wrIrqSt   = take && avsWrite && hitIrqSt &&
                                avsByteEnable[0];
  wire logic        wrIrqMsk  = take && avsWrite && hitIrqMsk &&
                                avsByteEnable[0];
  wire logic        strStep   = take && avsRead && hitStrDat;

  wire logic [15:0] hitLen    = hitDate ? DATE_LEN :
                                hitRel  ? {8'h00, REL_LEN} :
                                          {8'h00, COMPAT_LEN};

  // ******************************************
  // read data selection
  // ******************************************
  wire logic [31:0] strWord   = stringFault ? 32'h00000000 :  // [R11]
                                {16'h0000, hitLen};           // [R2] [R5]
  wire logic [31:0] lastWord  = {23'h000000, lastFailed_reg, 5'h00,
                                 lastCause_reg};
  wire logic [31:0] rdData    =
    strHit    ? strWord :
    hitLastSt ? lastWord :
    hitStrLen ? {24'h000000, strIf.len} :
    hitStrDat ? {24'h000000, strIf.dataByte} :
    hitIrqSt  ? {29'h00000000, irqStatus_reg} :
    hitIrqMsk ? {29'h00000000, irqMask_reg} : 32'h00000000;

  assign avsWaitRequest = (avsRead || avsWrite) &&
                          !(busState_reg == BUS_ANSWER && clkEn);

  // ******************************************
  // string reader
  // ******************************************
  assign strIf.sel     = hitDate ? SEL_DATE :
                         hitRel  ? SEL_RELEASE : SEL_COMPAT;
  assign strIf.load    = rdStrOk;                      // [R2] [R13]
  assign strIf.advance = strStep;

  mrd_string_reader #(
    .DATE_STR   (DATE_STR),
    .DATE_N     (DATE_LEN[7:0]),
    .REL_STR    (REL_STR),
    .REL_N      (REL_LEN),
    .COMPAT_STR (COMPAT_STR),
    .COMPAT_N   (COMPAT_LEN)
  ) uReader (
    .clk     (clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .strPort (strIf.reader)
  );

  // ******************************************
  // bus answer one cycle after the take
  // ******************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busState_reg <= BUS_IDLE;
      avsReadData  <= 32'h00000000;
    end
    else if (clkEn)
    begin
      case (busState_reg)
        BUS_IDLE:
        begin
          if (take)
          begin
            busState_reg <= BUS_ANSWER;
            avsReadData  <= avsRead ? rdData : 32'h00000000;
          end
        end
        BUS_ANSWER:
        begin
          busState_reg <= BUS_IDLE;
        end
        default:
        begin
          busState_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // ******************************************
  // outcome of the last string command
  // ******************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lastFailed_reg <= 1'b0;
      lastCause_reg  <= ERR_NONE;
    end
    else if (clkEn)
    begin
      if (rdStrOk)
      begin
        lastFailed_reg <= 1'b0;
        lastCause_reg  <= ERR_NONE;
      end
      else if (rdStrFail || wrReject)                  // [R1] [R4] [R12]
      begin
        lastFailed_reg <= 1'b1;
        lastCause_reg  <= ERR_EXECUTION_FAILURE;       // [R11]
      end
    end
  end

  // ******************************************
  // interrupts: set wins over write-one clear
  // ******************************************
  assign irqEvents[IRQ_WR_REJECT] = wrReject;
  assign irqEvents[IRQ_RD_FAIL]   = rdStrFail;
  assign irqEvents[IRQ_STR_DONE]  = strStep && !strIf.atEnd &&
                                    (strIf.dataByte == CH_NUL);
  assign irqClear       = wrIrqSt ? avsWriteData[IRQ_W-1:0] : '0;
  assign irqStatus_next = (irqStatus_reg & ~irqClear) | irqEvents;
  assign irq            = |(irqStatus_reg & irqMask_reg);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqStatus_reg <= IRQ_STATUS_RST;
      irqMask_reg   <= IRQ_MASK_RST;
    end
    else if (clkEn)
    begin
      irqStatus_reg <= irqStatus_next;
      if (wrIrqMsk)
      begin
        irqMask_reg <= avsWriteData[IRQ_W-1:0];
      end
    end
  end

  // ******************************************
  // checks
  // ******************************************
  sequence sGoodRead(logic h);
    take && avsRead && h && !stringFault;
  endsequence

  sequence sWrite(logic h);
    take && avsWrite && h;
  endsequence

  sequence sRefused;
    lastFailed_reg && lastCause_reg == ERR_EXECUTION_FAILURE &&
    $stable(strIf.len) && $stable(strIf.dataByte);
  endsequence

  a_date_write_refused: assert property ( // [R1]
    @(posedge clk) disable iff (!rstn)
    sWrite(hitDate) |=> sRefused ##0 irqStatus_reg[IRQ_WR_REJECT])
    else $error("write to build date not refused");

  a_date_read_len: assert property ( // [R2]
    @(posedge clk) disable iff (!rstn)
    sGoodRead(hitDate) |=> avsReadData == 32'h0000000C &&
      strIf.len == 8'h0C && strIf.dataByte == DATE_STR[7:0] &&
      !lastFailed_reg)
    else $error("build date read wrong");

  a_date_format: assert property ( // [R3]
    @(posedge clk) disable iff (!rstn)
    sGoodRead(hitDate) |=> DATE_STR[23:16] == CH_HYPHEN &&
      DATE_STR[55:48] == CH_HYPHEN && DATE_STR[95:88] == CH_NUL &&
      strIf.dataByte >= CH_ZERO && strIf.dataByte <= 8'h33)
    else $error("date string malformed");

  a_rel_write_refused: assert property ( // [R4]
    @(posedge clk) disable iff (!rstn)
    sWrite(hitRel) |=> sRefused)
    else $error("write to release not refused");

  a_rel_read_len: assert property ( // [R5]
    @(posedge clk) disable iff (!rstn)
    sGoodRead(hitRel) |=> avsReadData == {24'h000000, REL_LEN} &&
      strIf.len == REL_LEN && REL_LEN <= 8'(STR_MAX) &&
      (!avsWaitRequest || !clkEn))
    else $error("release read wrong");

  a_rel_fields: assert property ( // [R6]
    @(posedge clk) disable iff (!rstn)
    sGoodRead(hitRel) |=> REL_STR[7:0] == 8'h50 &&
      REL_STR[15:8] == 8'h56 && REL_STR[23:16] == CH_SPACE &&
      strIf.dataByte == 8'h50 && strIf.len == REL_LEN)
    else $error("release string lacks protocol field");

  a_fail_zero: assert property ( // [R11]
    @(posedge clk) disable iff (!rstn)
    (take && avsRead && strHit && stringFault) |=>
      avsReadData == 32'h00000000 && lastFailed_reg &&
      irqStatus_reg[IRQ_RD_FAIL])
    else $error("failed read did not answer zero");

  a_compat_refused: assert property ( // [R12]
    @(posedge clk) disable iff (!rstn)
    sWrite(hitCompat) |=> sRefused ##0 COMPAT_LEN <= 8'(STR_MAX))
    else $error("write to compat release not refused");

  // compat names an older or equal protocol major.minor
  a_compat_not_newer: assert property ( // [R10]
    @(posedge clk) disable iff (!rstn)
    sGoodRead(hitCompat) |-> COMPAT_VERSIONS[95:80] <= REL_VERSIONS[95:80])
    else $error("compat release newer than release");

endmodule

// [tb/mrd_host_model.sv]
`timescale 1ns/1ps
module mrd_host_model (
  // clock
  input  wire logic                       clk,
  // avalon-mm master
  output logic [mrd_pkg::ADDR_W-1:0]      avsAddress,
  output logic                            avsRead,
  output logic                            avsWrite,
  output logic [mrd_pkg::DATA_W-1:0]      avsWriteData,
  output logic [3:0]                      avsByteEnable,
  input  wire logic [mrd_pkg::DATA_W-1:0] avsReadData,
  input  wire logic                       avsWaitRequest
);
  import mrd_pkg::*;

  initial
  begin
    avsAddress    = 8'h00;
    avsRead       = 1'b0;
    avsWrite      = 1'b0;
    avsWriteData  = 32'h00000000;
    avsByteEnable = 4'hF;
  end

  // ******************************************
  // bus cycles
  // ******************************************
  // one access; hold until waitrequest low, then release
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avsAddress   <= a;
    avsRead      <= ~wr;
    avsWrite     <= wr;
    avsWriteData <= wd;
    // wait for the answer; only the bench watchdog ends a hang
    do
      @(posedge clk);
    while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    // released lines no longer show the last value
    avsRead      <= 1'b0;
    avsWrite     <= 1'b0;
    avsAddress   <= ~a;
    avsWriteData <= ~wd;
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import mrd_pkg::*;

  logic              clk;
  logic              rstn;
  logic              clkEn;
  logic              stringFault;
  logic              irq;
  logic [ADDR_W-1:0] avsAddress;
  logic              avsRead;
  logic              avsWrite;
  logic [DATA_W-1:0] avsWriteData;
  logic [3:0]        avsByteEnable;
  logic [DATA_W-1:0] avsReadData;
  logic              avsWaitRequest;
  int                fails;
  int                n_checks;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  mrd_string_regs #(
    .BUILD_DAY    (4),
    .BUILD_MONTH  (4),
    .BUILD_YEAR   (2001),
    .REL_VERSIONS (96'h01020A_FF0005_030201_0C6400),
    .COMPAT_HW_ON (1'b0)
  ) mrd_string_regs_i (
    .clk            (clk),
    .rstn           (rstn),
    .clkEn          (clkEn),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsWriteData   (avsWriteData),
    .avsByteEnable  (avsByteEnable),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest),
    .stringFault    (stringFault),
    .irq            (irq)
  );

  mrd_host_model mrd_host_model_i (
    .clk            (clk),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsWriteData   (avsWriteData),
    .avsByteEnable  (avsByteEnable),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest)
  );

  // ******************************************
  // helpers
  // ******************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    mrd_host_model_i.xfer(a, 1'b0, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    mrd_host_model_i.xfer(a, 1'b1, wd, d);
  endtask

  // length read, then fetch until the null byte and one past it
  task automatic check_string(input logic [7:0] a, input string s);
    rd_chk(a, 32'(s.len() + 1));
    for (int i = 0; i <= s.len(); i++)
      rd_chk(8'h48, (i < s.len()) ? 32'(s[i]) : 32'h0);
    rd_chk(8'h48, 32'h00000000);
  endtask

  // ******************************************
  // scenarios
  // ******************************************
  task automatic t_reset_vals;
    rd_chk(8'h4C, 32'h00000000);
    rd_chk(8'h50, 32'h00000000);
    rd_chk(8'h48, 32'h00000000);
    chk_irq(1'b0);
  endtask

  task automatic t_date;
    rd_chk(8'h14, 32'h0000000C);
    check_string(8'h14, "04-APR-2001");
    rd_chk(8'h4C, 32'h00000004);
    wr(8'h4C, 32'h00000004);
    rd_chk(8'h4C, 32'h00000000);
  endtask

  task automatic t_release;
    check_string(8'h18,
                 "PV 1.2.10:FW 255.0.5:HW 3.2.1:AS 12.100.0");
    check_string(8'h1C, "PV 1.0.0:FW 1.0.0:AS 1.0.0");
  endtask

  task automatic t_write_refused;
    logic [7:0]  a;
    logic [31:0] n;
    for (int i = 0; i < 3; i++)
    begin
      a = 8'h14 + 8'(4 * i);
      n = (i == 0) ? 32'h0000000C : (i == 1) ? 32'h0000002A : 32'h0000001B;
      wr(a, 32'h0000FFFF);
      rd_chk(8'h40, 32'h00000103);
      rd_chk(a, n);
      rd_chk(8'h40, 32'h00000000);
    end
    rd_chk(8'h14, 32'h0000000C);
    rd_chk(8'h4C, 32'h00000005);
  endtask

  task automatic t_read_fail;
    @(posedge clk);
    stringFault <= 1'b1;
    rd_chk(8'h18, 32'h00000000);
    rd_chk(8'h40, 32'h00000103);
    rd_chk(8'h4C, 32'h00000007);
    chk_irq(1'b0);
    wr(8'h50, 32'h00000002);
    chk_irq(1'b1);
    wr(8'h50, 32'h00000000);
    chk_irq(1'b0);
    wr(8'h50, 32'h00000002);
    wr(8'h4C, 32'h00000002);
    chk_irq(1'b0);
    rd_chk(8'h4C, 32'h00000005);
    @(posedge clk);
    stringFault <= 1'b0;
  endtask

  // request held while the clock enable is low, answered once it returns
  task automatic t_freeze;
    logic [31:0] d;
    @(posedge clk);
    clkEn <= 1'b0;
    fork
      mrd_host_model_i.xfer(8'h14, 1'b0, 32'h0, d);
      begin
        repeat (4) @(posedge clk);
        chk({31'h0, avsWaitRequest}, 32'h00000001);
        clkEn <= 1'b1;
      end
    join
    chk(d, 32'h0000000C);
  endtask

  // ******************************************
  // run control
  // ******************************************
  task automatic stop_test;
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    fails       = 0;
    n_checks    = 0;
    rstn        = 1'b0;
    clkEn       = 1'b1;
    stringFault = 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals;
    t_date;
    t_release;
    t_write_refused;
    t_read_fail;
    t_freeze;
    stop_test;
  end

  // about 120 accesses of a few cycles each
  initial
  begin
    #(100 * 5000);
    fails++;
    stop_test;
  end
endmodule
